// >>> verilog/cttrx_regs.sv
// Control and status register bank with byte queue of the contactless transceiver core.
//
// Operation
// - 64-byte queue behind one byte data port serves host and serial streams.
// - Flush write resets queue pointers and overflow flag; flush bit reads zero.
// - 7-bit fill count rises on data writes, falls on data reads.
// - Space-low flag when free space is at most the 6-bit threshold.
// - Fill-low flag when stored bytes are at most the threshold.
// - Stop and start strobes act at once on the timer; both read zero.
// - Identifier-copy bit loads 10 identifier bytes into queue, then clears itself.
// - Role bit one selects initiator, zero selects target.
// - 3-bit read-only count of valid bits in final received byte.
// - Send-start write begins transmission only during transceive command.
// - 3-bit alignment gives bit position of first received bit.
// - 3-bit field selects bits sent of final byte; zero sends eight.
// - Keep-after-collision zero clears bits received after a collision.
// - 5-bit first-collision position plus invalid flag for none or out-of-range.
// - Page-use makes the page field supply address bits A5 and A4.
// - Msb-order bit sets CRC bit order; a write during RF communication clears it.
// - Sync-detect waits for and prepends F0h sync byte.
// - Transmit-wait-field lets transmitter start only while RF field generated.
// - Receive-wait-field starts receive wait counter only after external field.
// - Mode-detector-off disables detector, which runs only during automatic anticollision.
// - Write to a full queue by host or core sets overflow flag.
`timescale 1ns/1ps
module cttrx_regs
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata_ff,
   output logic pready_ff,
   output logic pslverr_ff,
   input wire logic core_push,
   input wire logic [7:0] core_push_byte,
   input wire logic core_pop,
   output logic [7:0] core_pop_byte_ff,
   input wire logic [79:0] identifier_word,
   input wire logic transceive_active,
   input wire logic rx_bits_update,
   input wire logic [2:0] rx_bits_value,
   input wire logic coll_update,
   input wire logic coll_invalid,
   input wire logic [4:0] coll_index,
   input wire logic comm_active,
   input wire logic [1:0] comm_preset,
   input wire logic rf_field_generated,
   input wire logic ext_field_detected,
   input wire logic automatic_anticollision_command_active,
   input wire logic secure_signal_input,
   output logic timer_start_strobe_ff,
   output logic timer_stop_strobe_ff,
   output logic timer_running_ff,
   output logic initiator_ff,
   output logic send_start_ff,
   output logic [2:0] receive_alignment_ff,
   output logic [2:0] final_tx_bit_count_ff,
   output logic keep_after_collision_ff,
   output logic crc_msb_order_ff,
   output logic sync_detect_ff,
   output logic tx_start_permit_ff,
   output logic rx_wait_count_en_ff,
   output logic mode_detector_en_ff,
   output logic [15:0] crc_start_value_ff,
   output logic signal_input_active_ff,
   output logic signal_input_activity_event_ff,
   output logic space_low_flag_ff,
   output logic fill_low_flag_ff,
   output logic queue_overflow_error_ff
);
   import cttrx_pkg::*;

   logic [QPTR_W-1:0] wr_ptr_ff;
   logic [QPTR_W-1:0] rd_ptr_ff;
   logic [QCNT_W-1:0] queue_fill_count_ff;
   logic [5:0] warning_threshold_ff;
   logic identifier_copy_ff;
   logic [2:0] final_rx_valid_bits_ff;
   logic collision_position_invalid_ff;
   logic [4:0] collision_bit_index_ff;
   logic page_use_ff;
   logic [1:0] page_field_ff;
   logic transmit_wait_field_ff;
   logic receive_wait_field_ff;
   logic signal_input_polarity_ff;
   logic mode_detector_off_ff;
   logic [1:0] crc_preset_ff;
   logic [31:0] rd_mux;
   logic [7:0] qmem_rd;
   logic id_push;
   logic [7:0] id_byte;
   logic id_busy;
   logic id_done;
   logic [15:0] nxt_crc;

   // Page-use swaps the top two index bits for the page field.
   wire [5:0] raw_idx = paddr[7:2];
   wire [5:0] eff_idx = page_use_ff ? {page_field_ff, raw_idx[3:0]} : raw_idx;
   wire hit = (eff_idx == IDX_QDATA) | (eff_idx == IDX_QLVL) | (eff_idx == IDX_THR) |
              (eff_idx == IDX_CTRL) | (eff_idx == IDX_BITF) | (eff_idx == IDX_COLL) |
              (eff_idx == IDX_PAGE) | (eff_idx == IDX_MODE) | (eff_idx == IDX_QSTAT);

   // One wait state: ready rises on the first access cycle, the transfer ends on the second.
   wire acc = psel & penable;
   wire done = acc & pready_ff;
   wire wr_done = done & pwrite & hit;
   wire rd_done = done & ~pwrite & hit;
   wire wr_qlvl = wr_done & (eff_idx == IDX_QLVL);
   wire wr_thr = wr_done & (eff_idx == IDX_THR);
   wire wr_ctrl = wr_done & (eff_idx == IDX_CTRL);
   wire wr_bitf = wr_done & (eff_idx == IDX_BITF);
   wire wr_coll = wr_done & (eff_idx == IDX_COLL);
   wire wr_page = wr_done & (eff_idx == IDX_PAGE);
   wire wr_mode = wr_done & (eff_idx == IDX_MODE);

   // Queue traffic; the host wins over the identifier loader, which wins over the core.
   wire host_wr_q = wr_done & (eff_idx == IDX_QDATA);
   wire host_rd_q = rd_done & (eff_idx == IDX_QDATA);
   wire flush = wr_qlvl & pwdata[BIT_FLUSH];
   wire q_full = (queue_fill_count_ff == QDEPTH_CNT);
   wire q_empty = (queue_fill_count_ff == QCNT_ZERO);
   wire core_wr_q = core_push & ~host_wr_q & ~id_busy;
   wire push_req = host_wr_q | id_push | core_wr_q;
   wire [7:0] push_byte = host_wr_q ? pwdata[7:0] : (id_push ? id_byte : core_push_byte);
   wire push_ok = push_req & ~q_full & ~flush;
   wire pop_ok = (host_rd_q | core_pop) & ~q_empty & ~flush;
   wire ovfl_set = push_req & q_full;
   wire [QCNT_W-1:0] free_space = QDEPTH_CNT - queue_fill_count_ff;

   cttrx_qmem u_qmem
   (
      .pclk(pclk),
      .wr_en(push_ok),
      .wr_addr(wr_ptr_ff),
      .wr_data(push_byte),
      .rd_addr(rd_ptr_ff),
      .rd_data_ff(qmem_rd)
   );

   cttrx_idload u_idload
   (
      .pclk(pclk),
      .presetn(presetn),
      .start(identifier_copy_ff),
      .grant(~host_wr_q),
      .id_word(identifier_word),
      .push(id_push),
      .push_byte(id_byte),
      .busy(id_busy),
      .done(id_done)
   );

   assign core_pop_byte_ff = qmem_rd;

   // Read-back image; write-only strobes and reserved bits read as zero.
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      unique case (eff_idx)
         IDX_QDATA: rd_mux[7:0] = qmem_rd;
         IDX_QLVL: rd_mux[6:0] = queue_fill_count_ff;
         IDX_THR: rd_mux[5:0] = warning_threshold_ff;
         IDX_CTRL: rd_mux[7:0] = {2'b00, identifier_copy_ff, initiator_ff, 1'b0, final_rx_valid_bits_ff};
         IDX_BITF: rd_mux[7:0] = {1'b0, receive_alignment_ff, 1'b0, final_tx_bit_count_ff};
         IDX_COLL: rd_mux[7:0] = {keep_after_collision_ff, 1'b0, collision_position_invalid_ff,
                                  collision_bit_index_ff};
         IDX_PAGE: rd_mux[7:0] = {page_use_ff, 5'h00, page_field_ff};
         IDX_MODE: rd_mux[7:0] = {crc_msb_order_ff, sync_detect_ff, transmit_wait_field_ff,
                                  receive_wait_field_ff, signal_input_polarity_ff, mode_detector_off_ff,
                                  crc_preset_ff};
         IDX_QSTAT: rd_mux[7:0] = {3'b000, queue_overflow_error_ff, 2'b00, space_low_flag_ff, fill_low_flag_ff};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Bus answer; read data and error are captured on the first access cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end
      else
      begin
         pready_ff <= acc & ~pready_ff;
         if (acc & ~pready_ff)
         begin
            prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr_ff <= ~hit;
         end
      end
   end

   // Queue pointers, fill count and overflow; a new overflow wins over a flush.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wr_ptr_ff <= QPTR_ZERO;
         rd_ptr_ff <= QPTR_ZERO;
         queue_fill_count_ff <= QCNT_ZERO;
         queue_overflow_error_ff <= 1'b0;
      end
      else
      begin
         if (flush)
         begin
            wr_ptr_ff <= QPTR_ZERO;
            rd_ptr_ff <= QPTR_ZERO;
            queue_fill_count_ff <= QCNT_ZERO;
         end
         else
         begin
            wr_ptr_ff <= wr_ptr_ff + {5'h00, push_ok};
            rd_ptr_ff <= rd_ptr_ff + {5'h00, pop_ok};
            queue_fill_count_ff <= queue_fill_count_ff + {6'h00, push_ok} - {6'h00, pop_ok};
         end
         queue_overflow_error_ff <= ovfl_set | (queue_overflow_error_ff & ~flush);
      end
   end

   // Warning flags follow the fill count one cycle later.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         space_low_flag_ff <= 1'b0;
         fill_low_flag_ff <= 1'b1;
      end
      else
      begin
         space_low_flag_ff <= (free_space <= {1'b0, warning_threshold_ff});
         fill_low_flag_ff <= (queue_fill_count_ff <= {1'b0, warning_threshold_ff});
      end
   end

   // Control register and timer strobes; stop wins if both strobes arrive together.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         timer_start_strobe_ff <= 1'b0;
         timer_stop_strobe_ff <= 1'b0;
         timer_running_ff <= 1'b0;
         identifier_copy_ff <= 1'b0;
         initiator_ff <= 1'b0;
         final_rx_valid_bits_ff <= 3'b000;
      end
      else
      begin
         timer_stop_strobe_ff <= wr_ctrl & pwdata[BIT_TSTOP];
         timer_start_strobe_ff <= wr_ctrl & pwdata[BIT_TSTART] & ~pwdata[BIT_TSTOP];
         if (wr_ctrl & pwdata[BIT_TSTOP])
         begin
            timer_running_ff <= 1'b0;
         end
         else if (wr_ctrl & pwdata[BIT_TSTART])
         begin
            timer_running_ff <= 1'b1;
         end
         // A fresh host write of the copy bit wins over the loader's self-clear.
         if (wr_ctrl & pwdata[BIT_IDCOPY])
         begin
            identifier_copy_ff <= 1'b1;
         end
         else if (id_done)
         begin
            identifier_copy_ff <= 1'b0;
         end
         if (wr_ctrl)
         begin
            initiator_ff <= pwdata[BIT_ROLE];
         end
         if (rx_bits_update)
         begin
            final_rx_valid_bits_ff <= rx_bits_value;
         end
      end
   end

   // Bit framing, collision and page registers.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         send_start_ff <= 1'b0;
         receive_alignment_ff <= 3'b000;
         final_tx_bit_count_ff <= 3'b000;
         keep_after_collision_ff <= 1'b1;
         collision_position_invalid_ff <= 1'b1;
         collision_bit_index_ff <= RST_CPOS;
         page_use_ff <= 1'b0;
         page_field_ff <= 2'b00;
         warning_threshold_ff <= RST_THR;
      end
      else
      begin
         send_start_ff <= wr_bitf & pwdata[BIT_SEND] & transceive_active;
         if (wr_bitf)
         begin
            receive_alignment_ff <= pwdata[6:4];
            final_tx_bit_count_ff <= pwdata[2:0];
         end
         if (wr_coll)
         begin
            keep_after_collision_ff <= pwdata[BIT_KEEP];
         end
         if (coll_update)
         begin
            collision_position_invalid_ff <= coll_invalid;
            collision_bit_index_ff <= coll_index;
         end
         if (wr_page)
         begin
            page_use_ff <= pwdata[BIT_PUSE];
            page_field_ff <= pwdata[1:0];
         end
         if (wr_thr)
         begin
            warning_threshold_ff <= pwdata[5:0];
         end
      end
   end

   // CRC start value: the framing choice overrides the preset during communication.
   always_comb
   begin
      unique case (comm_active ? comm_preset : crc_preset_ff)
         2'b00: nxt_crc = CRC_P0;
         2'b01: nxt_crc = CRC_P1;
         2'b10: nxt_crc = CRC_P2;
         2'b11: nxt_crc = CRC_P3;
      endcase
   end

   // General transmit and receive settings and the gates they drive.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         crc_msb_order_ff <= RST_MODE[BIT_MSB];
         sync_detect_ff <= RST_MODE[BIT_SYNC];
         transmit_wait_field_ff <= RST_MODE[BIT_TXW];
         receive_wait_field_ff <= RST_MODE[BIT_RXW];
         signal_input_polarity_ff <= RST_MODE[BIT_POL];
         mode_detector_off_ff <= RST_MODE[BIT_MDOFF];
         crc_preset_ff <= RST_MODE[1:0];
         tx_start_permit_ff <= 1'b0;
         rx_wait_count_en_ff <= 1'b0;
         mode_detector_en_ff <= 1'b0;
         crc_start_value_ff <= CRC_P0;
         signal_input_active_ff <= 1'b0;
         signal_input_activity_event_ff <= 1'b0;
      end
      else
      begin
         if (wr_mode)
         begin
            crc_msb_order_ff <= pwdata[BIT_MSB] & ~comm_active;
            sync_detect_ff <= pwdata[BIT_SYNC];
            transmit_wait_field_ff <= pwdata[BIT_TXW];
            receive_wait_field_ff <= pwdata[BIT_RXW];
            signal_input_polarity_ff <= pwdata[BIT_POL];
            mode_detector_off_ff <= pwdata[BIT_MDOFF];
            crc_preset_ff <= pwdata[1:0];
         end
         tx_start_permit_ff <= ~transmit_wait_field_ff | rf_field_generated;
         rx_wait_count_en_ff <= ~receive_wait_field_ff | ext_field_detected;
         mode_detector_en_ff <= automatic_anticollision_command_active & ~mode_detector_off_ff;
         crc_start_value_ff <= nxt_crc;
         signal_input_active_ff <= signal_input_polarity_ff ? secure_signal_input : ~secure_signal_input;
         signal_input_activity_event_ff <= wr_mode & (pwdata[BIT_POL] != signal_input_polarity_ff);
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_flush_wr;
      wr_qlvl & pwdata[BIT_FLUSH] & ~ovfl_set;
   endsequence

   chk_flush_clears: assert property (s_flush_wr |=> queue_fill_count_ff == QCNT_ZERO && !queue_overflow_error_ff)
      else $error("flush did not empty the queue");
   chk_fill_count: assert property (push_ok && !pop_ok && !flush |=> queue_fill_count_ff == $past(queue_fill_count_ff) + QCNT_ONE)
      else $error("fill count did not rise on push");
   chk_empty_read: assert property (host_rd_q && q_empty |=> queue_fill_count_ff == QCNT_ZERO)
      else $error("empty read changed fill count");
   chk_space_low: assert property (##1 space_low_flag_ff == ($past(free_space) <= {1'b0, $past(warning_threshold_ff)}))
      else $error("space-low flag wrong");
   chk_fill_low: assert property (##1 fill_low_flag_ff == ($past(queue_fill_count_ff) <= {1'b0, $past(warning_threshold_ff)}))
      else $error("fill-low flag wrong");
   chk_overflow_set: assert property (push_req && q_full && !pop_ok && !flush |=> queue_overflow_error_ff && queue_fill_count_ff == QDEPTH_CNT)
      else $error("overflow not flagged");
   chk_timer_stop: assert property (wr_ctrl && pwdata[BIT_TSTOP] |=> timer_stop_strobe_ff && !timer_running_ff)
      else $error("timer did not stop");

   sequence s_copy_start;
      wr_ctrl & pwdata[BIT_IDCOPY] & ~id_busy & ~identifier_copy_ff;
   endsequence

   chk_id_copy_ends: assert property (s_copy_start ##1 (!wr_done)[*1] |-> ##[1:400] !identifier_copy_ff)
      else $error("identifier copy bit never cleared");
   chk_send_gate: assert property (send_start_ff |-> $past(transceive_active) && $past(wr_bitf))
      else $error("send start without transceive");
   chk_pol_event: assert property (wr_mode && pwdata[BIT_POL] != signal_input_polarity_ff |=> signal_input_activity_event_ff)
      else $error("polarity change lost its event");
endmodule : cttrx_regs

// >>> verilog/cttrx_pkg.sv
// Shared constants, register map and types of the contactless transceiver control bank.
package cttrx_pkg;
   // Queue geometry.
   localparam int QPTR_W = 6;
   localparam int QCNT_W = 7;
   localparam logic [QCNT_W-1:0] QDEPTH_CNT = 7'h40;
   localparam logic [QCNT_W-1:0] QCNT_ZERO = 7'h00;
   localparam logic [QPTR_W-1:0] QPTR_ZERO = 6'h00;
   localparam logic [QCNT_W-1:0] QCNT_ONE = 7'h01;
   // Register indices; the byte address is four times the index.
   localparam logic [5:0] IDX_QDATA = 6'h09;
   localparam logic [5:0] IDX_QLVL = 6'h0A;
   localparam logic [5:0] IDX_THR = 6'h0B;
   localparam logic [5:0] IDX_CTRL = 6'h0C;
   localparam logic [5:0] IDX_BITF = 6'h0D;
   localparam logic [5:0] IDX_COLL = 6'h0E;
   localparam logic [5:0] IDX_PAGE = 6'h10;
   localparam logic [5:0] IDX_MODE = 6'h11;
   localparam logic [5:0] IDX_QSTAT = 6'h3E;
   // Field positions.
   localparam int BIT_FLUSH = 7;
   localparam int BIT_TSTOP = 7;
   localparam int BIT_TSTART = 6;
   localparam int BIT_IDCOPY = 5;
   localparam int BIT_ROLE = 4;
   localparam int BIT_SEND = 7;
   localparam int BIT_KEEP = 7;
   localparam int BIT_CINV = 5;
   localparam int BIT_PUSE = 7;
   localparam int BIT_MSB = 7;
   localparam int BIT_SYNC = 6;
   localparam int BIT_TXW = 5;
   localparam int BIT_RXW = 4;
   localparam int BIT_POL = 3;
   localparam int BIT_MDOFF = 2;
   localparam int BIT_OVFL = 4;
   localparam int BIT_SPLOW = 1;
   localparam int BIT_FLLOW = 0;
   // Reset values.
   localparam logic [5:0] RST_THR = 6'h08;
   localparam logic [7:0] RST_MODE = 8'h3B;
   localparam logic [4:0] RST_CPOS = 5'h00;
   // CRC co-processor start values per preset code.
   localparam logic [15:0] CRC_P0 = 16'h0000;
   localparam logic [15:0] CRC_P1 = 16'h6363;
   localparam logic [15:0] CRC_P2 = 16'hA671;
   localparam logic [15:0] CRC_P3 = 16'hFFFF;
   // Identifier copy length in bytes.
   localparam logic [3:0] ID_BYTES = 4'hA;
   localparam logic [3:0] ID_ZERO = 4'h0;
   localparam logic [3:0] ID_ONE = 4'h1;
   // Identifier loader states.
   typedef enum logic [0:0] {CTTRX_LD_IDLE = 1'b0, CTTRX_LD_RUN = 1'b1} cttrx_ld_state_t;
endpackage : cttrx_pkg

// >>> verilog/cttrx_qmem.sv
// Byte storage of the 64-entry queue with a registered read port.
`timescale 1ns/1ps
module cttrx_qmem
(
   input wire logic pclk,
   input wire logic wr_en,
   input wire logic [cttrx_pkg::QPTR_W-1:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [cttrx_pkg::QPTR_W-1:0] rd_addr,
   output logic [7:0] rd_data_ff
);
   import cttrx_pkg::*;

   logic [7:0] mem [0:63];

   // No reset on the array; the head byte of an empty queue is unspecified anyway.
   always_ff @(posedge pclk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
      rd_data_ff <= mem[rd_addr];
   end
endmodule : cttrx_qmem

// >>> verilog/cttrx_idload.sv
// Sequencer that copies the stored 10-byte identifier into the queue, one byte per granted cycle.
`timescale 1ns/1ps
module cttrx_idload
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic grant,
   input wire logic [79:0] id_word,
   output logic push,
   output logic [7:0] push_byte,
   output logic busy,
   output logic done
);
   import cttrx_pkg::*;

   cttrx_ld_state_t state_ff;
   logic [3:0] idx_ff;

   // Bytes leave lowest first; a refused slot simply waits for the next grant.
   assign busy = (state_ff == CTTRX_LD_RUN);
   assign push = busy & grant;
   assign push_byte = id_word[{idx_ff, 3'b000} +: 8];
   assign done = push & (idx_ff == ID_BYTES - ID_ONE);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_ff <= CTTRX_LD_IDLE;
         idx_ff <= ID_ZERO;
      end
      else
      begin
         unique case (state_ff)
            CTTRX_LD_IDLE:
            begin
               idx_ff <= ID_ZERO;
               if (start)
               begin
                  state_ff <= CTTRX_LD_RUN;
               end
            end
            CTTRX_LD_RUN:
            begin
               if (done)
               begin
                  state_ff <= CTTRX_LD_IDLE;
               end
               else if (push)
               begin
                  idx_ff <= idx_ff + ID_ONE;
               end
            end
         endcase
      end
   end
endmodule : cttrx_idload

// >>> bench/cttrx_core_model.sv
// Behavioural model of the transceiver core that sits behind the register bank.
`timescale 1ns/1ps
module cttrx_core_model
(
   input wire logic pclk,
   output logic transceive_active,
   output logic [2:0] rx_bits_value,
   output logic coll_invalid,
   output logic [4:0] coll_index,
   output logic [1:0] comm_preset,
   output logic rf_field_generated,
   output logic ext_field_detected,
   output logic automatic_anticollision_command_active,
   output logic secure_signal_input,
   output logic [7:0] core_push_byte,
   output logic [79:0] identifier_word
);
   logic [23:0] lvl;
   // Identifier value is arbitrary.
   assign identifier_word = 80'h0123456789ABCDEF0246;
   assign {transceive_active, rx_bits_value, coll_invalid, coll_index, comm_preset} = lvl[23:12];
   assign {rf_field_generated, ext_field_detected, automatic_anticollision_command_active, secure_signal_input} = lvl[11:8];
   assign core_push_byte = lvl[7:0];
   // Levels wander every cycle; update strobes come from the bench, so stored fields change only when it pulses them.
   initial lvl = 24'h000000;
   always @(posedge pclk)
   begin
      lvl <= 24'($urandom);
   end
endmodule : cttrx_core_model

// >>> bench/tb.sv
// Self-checking testbench of the contactless transceiver control bank.
`timescale 1ns/1ps
module tb;
   import cttrx_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready_ff, pslverr_ff, initiator_ff, timer_running_ff;
   logic ta, cinv, rfg, efd, aca, ssi, upd;
   logic [7:0] paddr, pbyte, v;
   logic [31:0] pwdata, prdata_ff;
   logic [2:0] rbv;
   logic [4:0] cidx;
   logic [1:0] cpre;
   logic [79:0] idw;
   logic [16:0] notes[$];
   logic [16:0] x;
   logic [7:0] q[$];
   int err_count, checked, i, t;
   cttrx_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
      .core_push(1'b0), .core_push_byte(pbyte), .core_pop(1'b0), .core_pop_byte_ff(), .identifier_word(idw),
      .transceive_active(ta), .rx_bits_update(upd), .rx_bits_value(rbv), .coll_update(upd),
      .coll_invalid(cinv), .coll_index(cidx), .comm_active(1'b0), .comm_preset(cpre),
      .rf_field_generated(rfg), .ext_field_detected(efd), .automatic_anticollision_command_active(aca), .secure_signal_input(ssi),
      .timer_start_strobe_ff(), .timer_stop_strobe_ff(), .timer_running_ff(timer_running_ff),
      .initiator_ff(initiator_ff), .send_start_ff(), .receive_alignment_ff(), .final_tx_bit_count_ff(),
      .keep_after_collision_ff(), .crc_msb_order_ff(), .sync_detect_ff(), .tx_start_permit_ff(),
      .rx_wait_count_en_ff(), .mode_detector_en_ff(), .crc_start_value_ff(), .signal_input_active_ff(),
      .signal_input_activity_event_ff(), .space_low_flag_ff(), .fill_low_flag_ff(), .queue_overflow_error_ff());
   cttrx_core_model core (.pclk(pclk), .transceive_active(ta), .rx_bits_value(rbv), .coll_invalid(cinv),
      .coll_index(cidx), .comm_preset(cpre), .rf_field_generated(rfg), .ext_field_detected(efd),
      .automatic_anticollision_command_active(aca), .secure_signal_input(ssi), .core_push_byte(pbyte), .identifier_word(idw));
   // Free-running bus clock.
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // Prints the counts and the verdict, then ends the run.
   task complete_run();
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : complete_run
   // One APB transfer; the expected answer goes to the note queue. Called just after an edge.
   task xf(input logic w, input logic [5:0] ix, input logic [7:0] d, input logic [7:0] e, input logic [7:0] m,
      input logic er);
      int n;
      notes.push_back({er, m, e});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {ix, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready_ff !== 1'b1 && n < 20);
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
      begin
         err_count++;
         complete_run();
      end
      @(posedge pclk);
   endtask : xf
   task wr(input logic [5:0] ix, input logic [7:0] d);
      xf(1'b1, ix, d, 8'h00, 8'h00, 1'b0);
   endtask : wr
   task rd(input logic [5:0] ix, input logic [7:0] e, input logic [7:0] m);
      xf(1'b0, ix, 8'h00, e, m, 1'b0);
   endtask : rd
   task chk(input logic a, input logic b);
      checked++;
      if (a !== b)
      begin
         err_count++;
         $display("BAD t=%0t got %h exp %h", $time, a, b);
      end
   endtask : chk
   // Monitor: the oldest note is compared with each completed answer; upper data bits must be zero.
   always @(posedge pclk)
   begin
      if (psel === 1'b1 && penable === 1'b1 && pready_ff === 1'b1)
      begin
         x = notes.pop_front();
         checked++;
         if ({pslverr_ff, prdata_ff & {24'hFFFFFF, x[15:8]}} !== {x[16], 24'h000000, x[7:0] & x[15:8]})
         begin
            err_count++;
            $display("BAD t=%0t got %h exp %h", $time, {pslverr_ff, prdata_ff}, {x[16], 24'h0, x[7:0] & x[15:8]});
         end
      end
   end
   // Main sequence.
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata, err_count, checked, upd} = '0;
      void'($urandom(13675));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(IDX_THR, 8'h08, 8'hFF);
      rd(IDX_QLVL, 8'h00, 8'hFF);
      rd(IDX_MODE, 8'h3B, 8'hFF);
      rd(IDX_COLL, 8'hA0, 8'hFF);
      rd(IDX_BITF, 8'h00, 8'hFF);
      rd(IDX_PAGE, 8'h00, 8'hFF);
      rd(IDX_CTRL, 8'h00, 8'hF8);
      rd(IDX_QSTAT, 8'h01, 8'h13);
      xf(1'b0, 6'h01, 8'h00, 8'h00, 8'h00, 1'b1);
      // Fill to the brim at a random threshold, then one byte too many.
      t = $urandom_range(62, 1);
      wr(IDX_THR, t[7:0]);
      for (i = 1; i <= 64; i++)
      begin
         v = 8'($urandom);
         q.push_back(v);
         wr(IDX_QDATA, v);
         rd(IDX_QLVL, i[7:0], 8'hFF);
         rd(IDX_QSTAT, {6'h00, 64 - i <= t, i <= t}, 8'h13);
      end
      wr(IDX_QDATA, 8'h5A);
      rd(IDX_QLVL, 8'h40, 8'hFF);
      rd(IDX_QSTAT, 8'h12, 8'h13);
      for (i = 63; i >= 0; i--)
      begin
         rd(IDX_QDATA, q.pop_front(), 8'hFF);
         rd(IDX_QLVL, i[7:0], 8'hFF);
      end
      rd(IDX_QDATA, 8'h00, 8'h00);
      rd(IDX_QLVL, 8'h00, 8'hFF);
      wr(IDX_QDATA, 8'h11);
      wr(IDX_QLVL, 8'h80);
      rd(IDX_QLVL, 8'h00, 8'hFF);
      rd(IDX_QSTAT, 8'h01, 8'h13);
      // Identifier copy: ten bytes, lowest first, then the copy bit clears itself.
      wr(IDX_CTRL, 8'h20);
      repeat (12) @(posedge pclk);
      rd(IDX_QLVL, 8'h0A, 8'hFF);
      for (i = 0; i < 10; i++)
      begin
         rd(IDX_QDATA, idw[8*i +: 8], 8'hFF);
      end
      rd(IDX_CTRL, 8'h00, 8'h20);
      // Timer strobes and role.
      wr(IDX_CTRL, 8'h50);
      chk(timer_running_ff, 1'b1);
      chk(initiator_ff, 1'b1);
      rd(IDX_CTRL, 8'h10, 8'hF8);
      wr(IDX_CTRL, 8'h80);
      chk(timer_running_ff, 1'b0);
      chk(initiator_ff, 1'b0);
      v = 8'($urandom) & 8'hF7;
      wr(IDX_BITF, v);
      rd(IDX_BITF, v & 8'h77, 8'hFF);
      wr(IDX_BITF, 8'h00);
      wr(IDX_COLL, 8'h00);
      rd(IDX_COLL, 8'h20, 8'hFF);
      // The core loads receive status; the bench keeps the values the bank sampled at that edge.
      upd <= 1'b1;
      @(posedge pclk);
      upd <= 1'b0;
      t = rbv;
      v = {2'b00, cinv, cidx};
      rd(IDX_CTRL, t[7:0], 8'hFF);
      rd(IDX_COLL, v, 8'hFF);
      v = 8'($urandom);
      wr(IDX_MODE, v);
      rd(IDX_MODE, v, 8'hFF);
      // With paging on, the low index bits come from the address and the page gives the top bits.
      wr(IDX_PAGE, 8'h81);
      rd(6'h00, 8'h81, 8'hFF);
      rd(6'h01, v, 8'hFF);
      xf(1'b0, IDX_QDATA, 8'h00, 8'h00, 8'h00, 1'b1);
      wr(6'h00, 8'h00);
      rd(IDX_PAGE, 8'h00, 8'hFF);
      repeat (2) @(posedge pclk);
      complete_run();
   end
endmodule : tb
